// >>> qtd_defs.vh
// Constants for the quad text display memory controller.
// Assumes inclusion by the controller only; the FIFO does not include it.
`ifndef QTD_DEFS_VH
`define QTD_DEFS_VH
// I/O register offsets (3-bit I/O address)
`define IO_ATTR_KB0 3'h0
`define IO_CTRL1_KB1 3'h1
`define IO_CTRL2_KB2 3'h2
`define IO_CTRL3_KB3 3'h3
`define IO_STATUS 3'h4
// Control 1 fields
`define C1_SCREEN_LSB 0
`define C1_KBD_IRQ_EN 2
`define C1_AUTO_ATTR 4
`define C1_MEM_EN 5
// Control 2/3 fields, low bit = first channel of pair
`define CP_WR_SEL 0
`define CP_VID_EN0 1
`define CP_VID_EN1 2
`define CP_COPY_DIR 3
`define CP_COPY_GO 4
`define CP_CHG_DISP 5
// Memory layout
`define CHAR_AREA_BYTES 2048
`define ATTR_BIT 11
`define WIN_ADDR_W 12
`define MEM_ADDR_W 14
// Key codes
`define KEY_D_CODE 4'h0
`define KEY_0_CODE 4'ha
`define KEY_STAR_CODE 4'hb
`define KEY_HASH_CODE 4'hc
`define KEY_A_CODE 4'hd
`define KEY_B_CODE 4'he
`define KEY_C_CODE 4'hf
// Raw key numbers from the receivers
`define RAW_KEY_0 4'h0
`define RAW_KEY_STAR 4'ha
`define RAW_KEY_HASH 4'hb
`define RAW_KEY_A 4'hc
`define RAW_KEY_B 4'hd
`define RAW_KEY_C 4'he
`define RAW_KEY_D 4'hf
// Blank colour combination
`define BLANK_COMBO 7'h00
// Frame time and clock
`define FRAME_TIME_US 16660
`define CLK_MHZ 100
`endif

// >>> qtd_fifo.v
// Synchronous FIFO, parameterised width and depth.
// Assumes one clock and synchronous active-low reset.
`timescale 1ns/1ps
module qtd_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire clk_sys_i,
  input wire rst_n_i,
  // Fill side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // Drain side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [AW-1:0] rd_ptr;
  reg [AW-1:0] wr_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;
  // Honest full and empty
  assign in_ready_o = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o = store[rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  // Pointer and count update
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rd_ptr <= {AW{1'b0}};
      wr_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        store[wr_ptr] <= in_data_i;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule

// >>> qtd_host_model.sv
// Host processor model issuing memory and I/O cycles.
// Assumes strobes change on the falling edge; acks pulse one cycle.
`timescale 1ns/1ps
module host_bus_model (
  // Clock
  input wire clk_sys_i,
  // Memory cycle
  output logic [19:0] mem_addr_o = 20'h0,
  output logic mem_rd_o = 1'b0,
  output logic mem_wr_o = 1'b0,
  output logic [7:0] mem_wdata_o = 8'h0,
  input wire [7:0] mem_rdata_i,
  input wire mem_ack_i,
  // I/O cycle
  output logic [2:0] io_addr_o = 3'h0,
  output logic io_rd_o = 1'b0,
  output logic io_wr_o = 1'b0,
  output logic [7:0] io_wdata_o = 8'h0,
  input wire [7:0] io_rdata_i,
  input wire io_ack_i
);
  // One cycle, held until acknowledged or the bound runs out
  task automatic cycle(input logic io, input logic wr, input logic [19:0] a, input logic [7:0] d,
                       output logic [7:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    @(negedge clk_sys_i); // Idle cycle between requests
    if (io) begin
      io_addr_o = a[2:0];
      io_wdata_o = d;
      io_wr_o = wr;
      io_rd_o = !wr;
    end else begin
      mem_addr_o = a;
      mem_wdata_o = d;
      mem_wr_o = wr;
      mem_rd_o = !wr;
    end
    for (n = 0; n < 64 && !ok; n++) begin
      @(negedge clk_sys_i);
      ok = io ? io_ack_i : mem_ack_i;
    end
    rd = io ? io_rdata_i : mem_rdata_i;
    {io_wr_o, io_rd_o, mem_wr_o, mem_rd_o} = 4'h0;
    io_wdata_o = ~d; // Released data shows no stale byte
    mem_wdata_o = ~d;
  endtask
endmodule

// >>> qtd_properties.sv
// Port assertions for the display memory controller.
// Assumes binding onto quad_text_display_memory_ctrl.
`timescale 1ns/1ps
module qtd_checker (
  // Clock and reset
  input wire clk_sys_i,
  input wire rst_n_i,
  // Host memory cycle
  input wire [19:0] mem_addr_i,
  input wire mem_rd_i,
  input wire mem_wr_i,
  input wire [7:0] win_base_strap_i,
  input wire [7:0] mem_rdata_o,
  input wire mem_ack_o,
  // Host I/O cycle
  input wire [2:0] io_addr_i,
  input wire io_rd_i,
  input wire io_wr_i,
  input wire [7:0] io_rdata_o,
  input wire io_ack_o,
  input wire kbd_irq_o,
  input wire [27:0] lut_index_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // Two quiet cycles at the start of a memory cycle
  sequence s_quiet2;
    !mem_ack_o ##1 !mem_ack_o;
  endsequence
  property p_ack_pulse; mem_ack_o |=> !mem_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("mem ack too long");
  property p_min_wait; $rose(mem_rd_i || mem_wr_i) |-> s_quiet2; endproperty
  a_min_wait: assert property (p_min_wait) else $error("mem ack too early");
  property p_ack_req; mem_ack_o |-> $past(mem_rd_i || mem_wr_i); endproperty
  a_ack_req: assert property (p_ack_req) else $error("mem ack without cycle");
  property p_ack_hit; mem_ack_o |-> $past(mem_addr_i[19:12]) == win_base_strap_i; endproperty
  a_ack_hit: assert property (p_ack_hit) else $error("ack outside window");
  property p_rdata_hold; !mem_ack_o |-> $stable(mem_rdata_o); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_io_answer; (io_rd_i || io_wr_i) && !io_ack_o |=> io_ack_o; endproperty
  a_io_answer: assert property (p_io_answer) else $error("io ack missing");
  property p_unmapped;
    io_ack_o && $past(io_rd_i) && $past(io_addr_i) > 3'h4 |-> io_rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rst_quiet;
    $rose(rst_n_i) |-> !mem_ack_o && !io_ack_o && !kbd_irq_o && lut_index_o == 28'h0;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
endmodule
bind quad_text_display_memory_ctrl qtd_checker u_chk (.*);

// >>> quad_text_display_memory_ctrl.v
// Display store, window mapping, attribute writes, copy, view select,
// video enables and keyboard capture for a four-channel text display.
// Assumes a raster timing unit drives scan addresses and a host bus
// front end hands over decoded memory and I/O strobes.
`timescale 1ns/1ps
`include "qtd_defs.vh"
// Summary of operation
// (R1) Sixteen kilobytes of store, one four kilobyte region per channel.
// (R2) Each region holds a character half and an attribute half.
// (R3) One strapped four kilobyte host window serves all regions.
// (R4) Host I/O write selects which region answers window accesses.
// (R5) Software can disable response to host memory cycles.
// (R6) Each screen position owns one byte holding its character code.
// (R7) Attribute byte sits 2048 bytes above its character byte.
// (R8) Auto-attribute mode also writes latched attribute on character writes.
// (R9) One attribute latch serves all four channels.
// (R10) Host control write turns auto-attribute mode on or off.
// (R11) Refresh scans continuously; host access interleaves without disturbance.
// (R12) Colour is 3 red, 3 green, 2 blue bits; sync on green. Sync here drives video_sync_o, not green.
// (R13) Each video channel has its own host enable.
// (R14) Each channel has a 128-entry colour table input path.
// (R15) Low seven attribute bits select the colour table entry.
// (R16) Entry zero is all black and forces blanking.
// (R17) Copies only within pairs A-B and C-D, direction chosen.
// (R18) Copy writes refresh data of source into destination; host unimpeded.
// (R19) View select picks pair region feeding a screen, contents untouched.
// (R20) Keys map to 4-bit codes; 0 is 1010, star is 1011.
// (R21) Keyboard register: low nibble code, high nibble requesting keyboards.
// (R22) Interrupt raised while any keyboard has data.
// (R23) Hash 1100, A 1101, B 1110, C 1111, D 0000.
// (R24) I/O offset zero writes attribute latch, reads keyboard 0.
// (R25) Host memory acknowledge waits for arbitration grant.
// (R26) Reading a keyboard register clears its request and interrupt.
module quad_text_display_memory_ctrl #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  // Clock and reset
  input wire clk_sys_i,
  input wire rst_n_i,
  // Host memory cycle
  input wire [19:0] mem_addr_i,
  input wire mem_rd_i,
  input wire mem_wr_i,
  input wire [7:0] mem_wdata_i,
  input wire [7:0] win_base_strap_i,
  output reg [7:0] mem_rdata_o,
  output reg mem_ack_o,
  // Host I/O cycle
  input wire [2:0] io_addr_i,
  input wire io_rd_i,
  input wire io_wr_i,
  input wire [7:0] io_wdata_i,
  output reg [7:0] io_rdata_o,
  output reg io_ack_o,
  output reg kbd_irq_o,
  // Raster scan
  input wire [10:0] scan_addr_i,
  input wire scan_req_i,
  input wire scan_sync_i,
  input wire scan_blank_i,
  input wire frame_start_i,
  // Colour table: per channel entry select out, colour in
  output reg [27:0] lut_index_o,
  input wire [31:0] lut_colour_i,
  // Video out per channel
  output reg [11:0] video_red_o,
  output reg [11:0] video_green_o,
  output reg [7:0] video_blue_o,
  output reg [3:0] video_sync_o,
  // Keyboard receivers
  input wire [15:0] key_raw_i,
  input wire [3:0] key_strobe_i
);
  localparam FRAME_CYCLES = `FRAME_TIME_US * `CLK_MHZ;
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_DONE = 2'h2;

  // Display store, 16K bytes
  reg [7:0] store [0:16383]; // R1
  reg [1:0] wr_region;
  reg auto_attr;
  reg mem_en;
  reg kbd_irq_en;
  reg [7:0] attr_latch;
  reg [3:0] vid_en;
  reg [3:0] view_sel;
  reg [1:0] copy_dir;
  reg [1:0] copy_arm;
  reg [1:0] copy_run;
  reg [1:0] state;
  reg [31:0] frame_cnt;
  integer pr;
  wire win_hit;
  wire [`MEM_ADDR_W-1:0] host_addr;
  wire [`MEM_ADDR_W-1:0] attr_shadow;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire fifo_pop;
  wire [3:0] fifo_kbd;
  wire key_any;
  wire key_push;
  wire [1:0] key_ch;
  wire [7:0] key_word;

  // Window hit on strapped 4K boundary, gated by software enable
  assign win_hit = mem_en && (mem_addr_i[19:12] == win_base_strap_i); // R3 R5
  assign host_addr = {wr_region, mem_addr_i[`WIN_ADDR_W-1:0]}; // R4 R7
  assign attr_shadow = {wr_region, 1'b1, mem_addr_i[`ATTR_BIT-1:0]}; // R2 R8

  // Host memory access, granted only in slots with no refresh request
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      mem_ack_o <= 1'b0;
      mem_rdata_o <= 8'h00;
    end else begin
      mem_ack_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          if ((mem_rd_i || mem_wr_i) && win_hit)
            state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (!scan_req_i) begin // R11 R25
            if (mem_wr_i) begin
              store[host_addr] <= mem_wdata_i; // R6
              if (auto_attr && !mem_addr_i[`ATTR_BIT])
                store[attr_shadow] <= attr_latch; // R8 R9
            end else
              mem_rdata_o <= store[host_addr]; // Read data only moves on reads
            mem_ack_o <= 1'b1; // R25
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (!mem_rd_i && !mem_wr_i)
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
      // Copy: destination captures the source's refresh byte in the same slot
      for (pr = 0; pr < 2; pr = pr + 1) begin
        if (scan_req_i && copy_run[pr]) begin // R17 R18
          store[{pr[0], ~copy_dir[pr], 1'b0, scan_addr_i}] <= store[{pr[0], copy_dir[pr], 1'b0, scan_addr_i}];
          store[{pr[0], ~copy_dir[pr], 1'b1, scan_addr_i}] <= store[{pr[0], copy_dir[pr], 1'b1, scan_addr_i}];
        end
      end
    end
  end

  // Refresh attribute read on refresh slots, from the viewed region of the pair
  integer ch;
  reg [7:0] ref_attr [0:3];
  always @(posedge clk_sys_i) begin
    if (scan_req_i) begin // R11
      for (ch = 0; ch < 4; ch = ch + 1) begin
        ref_attr[ch] <= store[{view_sel[ch] ? (ch[1:0] ^ 2'h1) : ch[1:0], 1'b1, scan_addr_i}]; // R19
      end
    end
  end

  // Copy runs from the next frame start until a frame start finds it disarmed or a frame time passes without one
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      copy_run <= 2'h0;
      frame_cnt <= 32'h0;
    end else begin
      if (frame_start_i) begin
        copy_run <= copy_arm;
        frame_cnt <= 32'h0;
      end else if (frame_cnt != FRAME_CYCLES[31:0])
        frame_cnt <= frame_cnt + 32'h1;
      else
        copy_run <= 2'h0; // Frames stopped for a whole frame time: end the copy
    end
  end

  // Video: colour table index and outputs, blanking via entry zero
  integer v;
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      lut_index_o <= 28'h0;
      video_red_o <= 12'h000;
      video_green_o <= 12'h000;
      video_blue_o <= 8'h00;
      video_sync_o <= 4'h0;
    end else begin
      for (v = 0; v < 4; v = v + 1) begin
        if (vid_en[v] && !scan_blank_i) // R13
          lut_index_o[v*7 +: 7] <= ref_attr[v][6:0]; // R14 R15
        else
          lut_index_o[v*7 +: 7] <= `BLANK_COMBO; // R16
        video_red_o[v*3 +: 3] <= lut_colour_i[v*8+5 +: 3]; // R12
        video_green_o[v*3 +: 3] <= lut_colour_i[v*8+2 +: 3];
        video_blue_o[v*2 +: 2] <= lut_colour_i[v*8 +: 2];
        video_sync_o[v] <= scan_sync_i | scan_blank_i; // R12
      end
    end
  end

  // Keyboard decode: raw row/column key number to code
  function [3:0] key_code;
    input [3:0] k;
    begin
      case (k)
        `RAW_KEY_0: key_code = `KEY_0_CODE; // R20
        `RAW_KEY_STAR: key_code = `KEY_STAR_CODE;
        `RAW_KEY_HASH: key_code = `KEY_HASH_CODE; // R23
        `RAW_KEY_A: key_code = `KEY_A_CODE;
        `RAW_KEY_B: key_code = `KEY_B_CODE;
        `RAW_KEY_C: key_code = `KEY_C_CODE;
        `RAW_KEY_D: key_code = `KEY_D_CODE;
        default: key_code = k;
      endcase
    end
  endfunction

  // Key events queue as {channel bit, code}; the lowest strobed channel
  // wins a shared cycle, so receivers must not strobe together
  assign key_any = (key_strobe_i != 4'h0);
  assign key_push = key_any && fifo_in_ready;
  assign key_ch = key_strobe_i[0] ? 2'h0 : (key_strobe_i[1] ? 2'h1 : (key_strobe_i[2] ? 2'h2 : 2'h3));
  assign key_word = {4'h1 << key_ch, key_code(key_raw_i[{key_ch, 2'b00} +: 4])}; // R20 R23

  // Key event buffer between the receivers and the holding registers
  qtd_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_key_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(key_push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(key_word),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data)
  );

  // Drain one event per clock into its channel's holding register
  assign fifo_pop = fifo_out_valid;
  assign fifo_kbd = fifo_out_data[7:4];

  // Keyboard holding registers, pending flags
  reg [3:0] kbd_code [0:3];
  reg [3:0] kbd_pend;
  wire [3:0] kbd_rd;
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_kbd
      assign kbd_rd[k] = io_rd_i && (io_addr_i == k[2:0]) && !io_ack_o;
      always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
          kbd_code[k] <= 4'h0;
          kbd_pend[k] <= 1'b0;
        end else if (fifo_pop && fifo_kbd[k]) begin // set wins over clear
          kbd_code[k] <= fifo_out_data[3:0]; // R20
          kbd_pend[k] <= 1'b1;
        end else if (kbd_rd[k])
          kbd_pend[k] <= 1'b0; // R26
      end
    end
  endgenerate

  // Host I/O register file
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wr_region <= 2'h0;
      auto_attr <= 1'b0;
      mem_en <= 1'b0;
      kbd_irq_en <= 1'b0;
      attr_latch <= 8'h00;
      vid_en <= 4'h0;
      view_sel <= 4'h0;
      copy_dir <= 2'h0;
      copy_arm <= 2'h0;
      io_ack_o <= 1'b0;
      io_rdata_o <= 8'h00;
      kbd_irq_o <= 1'b0;
    end else begin
      io_ack_o <= (io_rd_i || io_wr_i) && !io_ack_o;
      kbd_irq_o <= kbd_irq_en && ((kbd_pend & ~kbd_rd) != 4'h0); // R22 R26
      if (io_wr_i && !io_ack_o) begin
        if (io_addr_i == `IO_ATTR_KB0)
          attr_latch <= io_wdata_i; // R24 R9
        else if (io_addr_i == `IO_CTRL1_KB1) begin
          wr_region <= io_wdata_i[`C1_SCREEN_LSB +: 2]; // R4
          kbd_irq_en <= io_wdata_i[`C1_KBD_IRQ_EN];
          auto_attr <= io_wdata_i[`C1_AUTO_ATTR]; // R10
          mem_en <= io_wdata_i[`C1_MEM_EN]; // R5
        end else if (io_addr_i == `IO_CTRL2_KB2 || io_addr_i == `IO_CTRL3_KB3) begin
          vid_en[{io_addr_i[0], 1'b0}] <= io_wdata_i[`CP_VID_EN0]; // R13
          vid_en[{io_addr_i[0], 1'b1}] <= io_wdata_i[`CP_VID_EN1];
          copy_dir[io_addr_i[0]] <= io_wdata_i[`CP_COPY_DIR]; // R17
          copy_arm[io_addr_i[0]] <= io_wdata_i[`CP_COPY_GO];
          view_sel[{io_addr_i[0], 1'b0}] <= io_wdata_i[`CP_CHG_DISP]; // R19
          view_sel[{io_addr_i[0], 1'b1}] <= io_wdata_i[`CP_CHG_DISP];
        end
      end
      if (io_rd_i && !io_ack_o) begin
        if (io_addr_i[2] == 1'b0)
          io_rdata_o <= {kbd_pend, kbd_code[io_addr_i[1:0]]}; // R21 R24
        else if (io_addr_i == `IO_STATUS)
          io_rdata_o <= {5'h00, scan_blank_i, scan_sync_i, kbd_irq_o};
        else
          io_rdata_o <= 8'h00;
      end
    end
  end
endmodule

// >>> tb_top.sv
// Self-checking bench for the display memory controller.
// Assumes the host model owns all host strobes.
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] STRAP = 8'h3c;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hold_scan = 1'b0;
  logic [10:0] scan_addr = 11'h0;
  logic scan_req = 1'b0;
  logic scan_sync = 1'b0;
  logic scan_blank = 1'b0;
  logic frame_start = 1'b0;
  logic [31:0] lut_colour = 32'h0;
  logic [15:0] key_raw = 16'h0;
  logic [3:0] key_strobe = 4'h0;
  logic pin_scan = 1'b0;
  logic [10:0] pin_addr = 11'h0;
  wire [27:0] lut_index;
  wire [11:0] video_red, video_green;
  wire [7:0] video_blue;
  wire [3:0] video_sync;
  wire [19:0] mem_addr;
  wire [7:0] mem_wdata, mem_rdata, io_wdata, io_rdata;
  wire [2:0] io_addr;
  wire mem_rd, mem_wr, mem_ack, io_rd, io_wr, io_ack, kbd_irq;
  integer seed = 32'h380b65dc;
  int n_mismatch = 0;
  int num_checks = 0;
  int r, t, k;
  logic [7:0] got, lat;
  logic [7:0] dat [4];
  logic [11:0] adr;
  logic ok, seen;
  host_bus_model u_host (.clk_sys_i(clk_sys_i), .mem_addr_o(mem_addr), .mem_rd_o(mem_rd), .mem_wr_o(mem_wr),
    .mem_wdata_o(mem_wdata), .mem_rdata_i(mem_rdata), .mem_ack_i(mem_ack), .io_addr_o(io_addr),
    .io_rd_o(io_rd), .io_wr_o(io_wr), .io_wdata_o(io_wdata), .io_rdata_i(io_rdata), .io_ack_i(io_ack));
  quad_text_display_memory_ctrl dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .mem_addr_i(mem_addr),
    .mem_rd_i(mem_rd), .mem_wr_i(mem_wr), .mem_wdata_i(mem_wdata), .win_base_strap_i(STRAP),
    .mem_rdata_o(mem_rdata), .mem_ack_o(mem_ack), .io_addr_i(io_addr), .io_rd_i(io_rd), .io_wr_i(io_wr),
    .io_wdata_i(io_wdata), .io_rdata_o(io_rdata), .io_ack_o(io_ack), .kbd_irq_o(kbd_irq),
    .scan_addr_i(scan_addr), .scan_req_i(scan_req), .scan_sync_i(scan_sync), .scan_blank_i(scan_blank),
    .frame_start_i(frame_start), .lut_index_o(lut_index), .lut_colour_i(lut_colour), .video_red_o(video_red),
    .video_green_o(video_green), .video_blue_o(video_blue), .video_sync_o(video_sync), .key_raw_i(key_raw),
    .key_strobe_i(key_strobe));
  // Clock
  initial forever #5 clk_sys_i = ~clk_sys_i;
  // Raster side traffic, refresh slots about one cycle in four
  always @(negedge clk_sys_i) begin
    scan_addr <= pin_scan ? pin_addr : 11'($random(seed));
    scan_req <= hold_scan | (2'($random(seed)) == 2'h0);
    {scan_sync, scan_blank} <= pin_scan ? 2'h0 : 2'($random(seed));
    frame_start <= 6'($random(seed)) == 6'h0;
    lut_colour <= $random(seed);
  end
  // Expected key code from the receiver's raw key number
  function automatic logic [3:0] key_code(input logic [3:0] raw);
    if (raw == 4'h0) return 4'ha;
    if (raw == 4'hf) return 4'h0;
    if (raw > 4'h9) return raw + 4'h1;
    return raw;
  endfunction
  // Control 1 value with memory response on
  function automatic logic [7:0] c1(input int sel, input logic auto_on, input logic irq_on);
    return {3'h1, auto_on, 1'b0, irq_on, 2'(sel)};
  endfunction
  task print_verdict;
    if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Host cycle that must be acknowledged
  task bus(input logic io, input logic wr, input logic [11:0] a, input logic [7:0] d);
    u_host.cycle(io, wr, io ? {17'h0, a[2:0]} : {STRAP, a}, d, got, ok);
    if (!ok) begin
      n_mismatch++;
      $display("Error %0t: no acknowledge", $time);
      print_verdict;
    end
  endtask
  // Main sequence
  initial begin
    repeat (16) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    u_host.cycle(1'b0, 1'b1, {STRAP, 12'h010}, 8'h5a, got, ok);
    chk({7'h0, ok}, 8'h00);
    for (t = 0; t < 3; t++) begin
      adr = (t == 0) ? 12'h7ff : {1'b0, 11'($random(seed))};
      for (r = 0; r < 4; r++) begin
        dat[r] = 8'($random(seed));
        bus(1'b1, 1'b1, 12'h1, c1(r, 1'b0, 1'b0));
        bus(1'b0, 1'b1, adr, dat[r]);
        bus(1'b0, 1'b1, adr | 12'h800, ~dat[r]);
      end
      for (r = 0; r < 4; r++) begin
        bus(1'b1, 1'b1, 12'h1, c1(r, 1'b0, 1'b0));
        bus(1'b0, 1'b0, adr, 8'h00);
        chk(got, dat[r]);
        bus(1'b0, 1'b0, adr | 12'h800, 8'h00);
        chk(got, ~dat[r]);
      end
    end
    u_host.cycle(1'b0, 1'b1, {STRAP ^ 8'h01, adr}, 8'h11, got, ok);
    chk({7'h0, ok}, 8'h00);
    lat = 8'($random(seed));
    bus(1'b1, 1'b1, 12'h0, lat);
    for (r = 2; r < 4; r++) begin
      bus(1'b1, 1'b1, 12'h1, c1(r, 1'b1, 1'b0));
      bus(1'b0, 1'b1, adr, 8'h41);
      bus(1'b0, 1'b0, adr | 12'h800, 8'h00);
      chk(got, lat);
    end
    bus(1'b1, 1'b1, 12'h0, ~lat);
    bus(1'b1, 1'b1, 12'h1, c1(3, 1'b0, 1'b0));
    bus(1'b0, 1'b1, adr, 8'h42);
    bus(1'b0, 1'b0, adr | 12'h800, 8'h00);
    chk(got, lat);
    // Host cycle stalled by a long refresh slot
    hold_scan = 1'b1;
    seen = 1'b0;
    fork
      bus(1'b0, 1'b1, adr, 8'h33);
      begin
        repeat (12) @(negedge clk_sys_i) seen = seen | mem_ack;
        hold_scan = 1'b0;
      end
    join
    chk({7'h0, seen}, 8'h00);
    bus(1'b0, 1'b0, adr, 8'h00);
    chk(got, 8'h33);
    // View select and video enables on a pinned scan address
    pin_addr = adr[10:0];
    pin_scan = 1'b1;
    bus(1'b1, 1'b1, 12'h2, 8'h02);
    repeat (40) @(negedge clk_sys_i);
    chk({1'b0, lut_index[6:0]}, {1'b0, ~dat[0][6:0]});
    chk({1'b0, lut_index[13:7]}, 8'h00);
    chk({video_red[2:0], video_green[2:0], video_blue[1:0]}, lut_colour[7:0]);
    chk({4'h0, video_sync}, 8'h00);
    bus(1'b1, 1'b1, 12'h2, 8'h22);
    repeat (40) @(negedge clk_sys_i);
    chk({1'b0, lut_index[6:0]}, {1'b0, ~dat[1][6:0]});
    // Copy A into B at the pinned address over several frames
    bus(1'b1, 1'b1, 12'h2, 8'h10);
    repeat (600) @(negedge clk_sys_i);
    bus(1'b1, 1'b1, 12'h2, 8'h00);
    pin_scan = 1'b0;
    bus(1'b1, 1'b1, 12'h1, c1(1, 1'b0, 1'b0));
    bus(1'b0, 1'b0, adr, 8'h00);
    chk(got, dat[0]);
    bus(1'b0, 1'b0, adr | 12'h800, 8'h00);
    chk(got, ~dat[0]);
    // Every key on rotating keyboard channels
    bus(1'b1, 1'b1, 12'h1, c1(0, 1'b0, 1'b1));
    for (k = 0; k < 16; k++) begin
      @(negedge clk_sys_i);
      key_raw = 16'($random(seed));
      key_raw[(k % 4) * 4 +: 4] = 4'(k);
      key_strobe = 4'(1 << (k % 4));
      @(negedge clk_sys_i);
      key_strobe = 4'h0;
      repeat (3) @(negedge clk_sys_i);
      chk({7'h0, kbd_irq}, 8'h01);
      bus(1'b1, 1'b0, 12'(k % 4), 8'h00);
      chk(got, {4'(1 << (k % 4)), key_code(4'(k))});
      repeat (3) @(negedge clk_sys_i);
      chk({7'h0, kbd_irq}, 8'h00);
    end
    bus(1'b1, 1'b0, 12'h5, 8'h00);
    chk(got, 8'h00);
    print_verdict;
  end
endmodule
